// [design/dds_pkg.sv]
// Purpose: Shared constants and types of the dynamic delay sync block
// Assumes: Cycles are periods of the distribution clock sys_clk
// Notes: Notes on behaviour follow
// Notes on behaviour
// - Qualification select 3 qualifies sync on output
// - Exempt outputs never stop during resync
// - One-shot accepts sync held two cycles or longer
// - Wait two qualifying falling edges before one-shot
// - Delay group low 5.5, fixed 8.5 cycles
// - Rise after 6 plus delay, fixed 10
// - Word is 4-bit address, 28-bit data
// - Word shifted most significant bit first
// - Data sampled on serial clock rise, strobe low
// - Strobe low-high-low loads addressed register
// - Reset bit write ignores other bits
// - Auto sync fires on register five write
// - Half step immediate, delay at next sync
// - Only first delay output qualifies sync
package dds_pkg;
	// Word layout
	localparam int WORD_W = 32;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 28;
	localparam int NREG   = 7;
	// Register addresses
	localparam logic [3:0] ADDR_R0  = 4'h0;
	localparam logic [3:0] ADDR_R3  = 4'h3;
	localparam logic [3:0] ADDR_R4  = 4'h4;
	localparam logic [3:0] ADDR_R5  = 4'h5;
	localparam logic [3:0] ADDR_R15 = 4'hf;
	localparam logic [2:0] IDX_R15  = 3'h6;
	// Default data field of every register
	localparam logic [27:0] DEF_DATA = 28'h0000000;
	// Field positions in the word
	localparam int RESET_POS   = 4;
	localparam int LOCK_POS    = 4;
	localparam int AUTO_POS    = 26;
	localparam int EX_DG_POS   = 19;
	localparam int EX_FX_POS   = 18;
	localparam int POLINV_POS  = 15;
	localparam int QUAL_LSB    = 11;
	localparam int HS_POS      = 10;
	localparam int DDLY_LSB    = 4;
	localparam int DDLY_W      = 10;
	localparam int DIV_LSB     = 16;
	localparam int DIV_W       = 11;
	localparam int ADLY_POS    = 13;
	localparam logic [1:0] QUAL_ON = 2'h3;
	localparam logic [10:0] DIV_MIN = 11'h002;
	// Timing in distribution cycles
	localparam int T_W          = 12;
	localparam int ONESHOT_CYC  = 3;
	localparam int DG_LOW_HALF  = 11;
	localparam int DG_LOW_CYC   = (DG_LOW_HALF + 1) / 2;
	localparam int FX_LOW_HALF  = 17;
	localparam int FX_LOW_CYC   = (FX_LOW_HALF + 1) / 2;
	localparam int DG_RISE_CYC  = 6;
	localparam int FX_RISE_CYC  = 10;
	// Sequencer states
	typedef enum {S_IDLE, S_FALL1, S_FALL2, S_LEAD, S_SHOT, S_RUN} dds_state_type;
endpackage

// [design/dds_serial_shift.sv]
// Purpose: Serial shift register on the programming clock
// Assumes: Clock stops while the latch strobe is high
// Notes: Word is read in the system domain while quiet
`timescale 1ns/1ps
module dds_serial_shift
	import dds_pkg::*;
(
	// Serial pins
	input  wire logic              ser_clk,
	input  wire logic              ser_data,
	input  wire logic              latch_strobe,
	// Assembled word
	output logic [WORD_W-1:0]      shift_word
);
	// Shift in while strobe low, first bit ends at the top
	always_ff @(posedge ser_clk) begin
		if (!latch_strobe) begin
			shift_word <= {shift_word[WORD_W-2:0], ser_data};
		end
	end
endmodule

// [design/dds_core.sv]
// Purpose: Serial register file and qualified sync sequencer
// Assumes: sys_clk is the distribution clock, cycles count on it
// Notes: Output clocks are modelled at distribution clock rate
`timescale 1ns/1ps
module dds_core
	import dds_pkg::*;
(
	// Clock and reset
	input  wire logic sys_clk,
	input  wire logic rst,
	// Serial programming pins
	input  wire logic ser_clk,
	input  wire logic ser_data,
	input  wire logic latch_strobe,
	// Sync pin
	input  wire logic sync_pin,
	// Clock outputs
	output logic      delay_group_out_a,
	output logic      delay_group_out_b,
	output logic      fixed_group_out_first,
	// Settings for analog stages, and write lock
	output logic      half_step_sel,
	output logic      analog_delay_sel,
	output logic      write_lock,
	// Status
	output logic      sync_busy,
	output logic      one_shot
);
	// Register address check
	function automatic logic reg_valid(input logic [3:0] a);
		return (a <= ADDR_R5) || (a == ADDR_R15);
	endfunction

	// Address to storage slot
	function automatic logic [2:0] reg_index(input logic [3:0] a);
		return (a == ADDR_R15) ? IDX_R15 : a[2:0];
	endfunction

	// Default word of a slot
	function automatic logic [WORD_W-1:0] reg_default(input logic [2:0] i);
		return {DEF_DATA, (i == IDX_R15) ? ADDR_R15 : {1'b0, i}};
	endfunction

	logic [WORD_W-1:0] shift_word;       // Word on serial domain
	logic [WORD_W-1:0] cap_q;            // Word taken at strobe rise
	logic [WORD_W-1:0] regs_q [NREG];    // Register slots
	logic              le_s1_q;          // Strobe sync stage one
	logic              le_s2_q;          // Strobe sync stage two
	logic              le_s3_q;          // Strobe edge history
	logic              load_q;           // Load pulse at strobe fall
	logic              sync_s1_q;        // Sync pin stage one
	logic              sync_s2_q;        // Sync pin stage two
	logic              lvl_q;            // Previous sync level
	logic              act_q;            // Registered sync assertion
	logic              auto_q;           // Auto sync request
	logic [DIV_W-1:0]  div_cnt_q;        // Delay group divider count
	logic              dg_clk_q;         // Delay group clock
	logic              dg_prev_q;        // Delay group clock history
	logic              fx_ph_q;          // Fixed group clock
	logic              dg_hold_q;        // Delay group forced low
	logic              fx_hold_q;        // Fixed group forced low
	dds_state_type     state_q;          // Sequencer state
	logic [T_W-1:0]    t_q;              // Cycles since one-shot start
	logic [DDLY_W-1:0] ddly_act_q;       // Delay in force

	// Shifter in the serial clock domain
	dds_serial_shift u_shift (
		.ser_clk      (ser_clk),
		.ser_data     (ser_data),
		.latch_strobe (latch_strobe),
		.shift_word   (shift_word)
	);

	// Decoded fields
	logic [3:0]        cap_addr;
	logic [WORD_W-1:0] r0;
	logic [WORD_W-1:0] r3;
	logic [WORD_W-1:0] r4;
	logic [WORD_W-1:0] r5;
	logic              auto_on;
	logic              dg_exempt;
	logic              fx_exempt;
	logic              qual_on;
	logic [DDLY_W-1:0] ddly;
	logic [DIV_W-1:0]  div_eff;
	logic              sync_lvl;
	logic              sync_evt;
	logic              start_req;
	logic              dg_fall;
	logic              in_seq;
	logic              in_shot;
	logic [T_W-1:0]    rise_at;
	logic [T_W-1:0]    fx_rise_at;
	logic [T_W-1:0]    last_at;

	assign cap_addr   = cap_q[ADDR_W-1:0];
	assign r0         = regs_q[reg_index(ADDR_R0)];
	assign r3         = regs_q[reg_index(ADDR_R3)];
	assign r4         = regs_q[reg_index(ADDR_R4)];
	assign r5         = regs_q[reg_index(ADDR_R5)];
	assign auto_on    = r3[AUTO_POS];
	assign dg_exempt  = r3[EX_DG_POS];
	assign fx_exempt  = r3[EX_FX_POS];
	assign qual_on    = (r3[QUAL_LSB +: 2] == QUAL_ON);
	assign ddly       = r4[DDLY_LSB +: DDLY_W];
	assign div_eff    = (r5[DIV_LSB +: DIV_W] < DIV_MIN) ? DIV_MIN : r5[DIV_LSB +: DIV_W];
	assign write_lock = regs_q[IDX_R15][LOCK_POS];
	// Half step acts at once, no sync needed
	assign half_step_sel    = r3[HS_POS];
	assign analog_delay_sel = r5[ADLY_POS];

	// Latch strobe synchroniser
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			le_s1_q <= 1'b0;
			le_s2_q <= 1'b0;
			le_s3_q <= 1'b0;
		end else begin
			le_s1_q <= latch_strobe;
			le_s2_q <= le_s1_q;
			le_s3_q <= le_s2_q;
		end
	end

	// Word capture at strobe rise, load at strobe fall
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			cap_q  <= {WORD_W{1'b0}};
			load_q <= 1'b0;
		end else begin
			if (le_s2_q && !le_s3_q) begin
				cap_q <= shift_word;
			end
			load_q <= le_s3_q && !le_s2_q;
		end
	end

	// Register file writes
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			for (int i = 0; i < NREG; i++) begin
				regs_q[i] <= reg_default(3'(i));
			end
		end else if (load_q && reg_valid(cap_addr)) begin
			if (write_lock && cap_addr != ADDR_R15) begin
				// Locked, word dropped
			end else if (cap_addr == ADDR_R0 && cap_q[RESET_POS]) begin
				// Reset write, other bits ignored
				for (int i = 0; i < NREG; i++) begin
					regs_q[i] <= reg_default(3'(i));
				end
			end else begin
				regs_q[reg_index(cap_addr)] <= cap_q;
			end
		end
	end

	// Sync pin synchroniser
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			sync_s1_q <= 1'b0;
			sync_s2_q <= 1'b0;
		end else begin
			sync_s1_q <= sync_pin;
			sync_s2_q <= sync_s1_q;
		end
	end

	// Level after polarity, counted only when held two cycles
	assign sync_lvl = sync_s2_q ^ r3[POLINV_POS];
	assign sync_evt = sync_lvl && lvl_q && !act_q;

	// Registered assertion state, set and cleared by a level held two cycles
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			lvl_q <= 1'b0;
			act_q <= 1'b0;
		end else begin
			lvl_q <= sync_lvl;
			if (sync_lvl && lvl_q) begin
				act_q <= 1'b1;
			end else if (!sync_lvl && !lvl_q) begin
				act_q <= 1'b0;
			end
		end
	end

	// Auto sync on write of the divider register
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			auto_q <= 1'b0;
		end else begin
			auto_q <= load_q && cap_addr == ADDR_R5 && !write_lock && auto_on;
		end
	end

	assign start_req = sync_evt || auto_q;

	// Delay group divider, restarts when released
	always_ff @(posedge sys_clk) begin
		if (rst || dg_hold_q) begin
			div_cnt_q <= {DIV_W{1'b0}};
		end else if (div_cnt_q >= div_eff - 11'h001) begin
			div_cnt_q <= {DIV_W{1'b0}};
		end else begin
			div_cnt_q <= div_cnt_q + 11'h001;
		end
	end

	// Delay group clock and its history
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			dg_clk_q  <= 1'b0;
			dg_prev_q <= 1'b0;
		end else begin
			dg_clk_q  <= !dg_hold_q && (div_cnt_q < (div_eff >> 1));
			dg_prev_q <= dg_clk_q;
		end
	end

	// Qualifying edge taken from the first delay output only
	assign dg_fall = dg_prev_q && !dg_clk_q;
	assign delay_group_out_a = dg_clk_q;
	assign delay_group_out_b = dg_clk_q;

	// Fixed group clock, divide by two
	always_ff @(posedge sys_clk) begin
		if (rst || fx_hold_q) begin
			fx_ph_q <= 1'b0;
		end else begin
			fx_ph_q <= !fx_ph_q;
		end
	end

	assign fixed_group_out_first = fx_ph_q;

	// Sequence timing points
	assign in_shot    = (state_q == S_SHOT);
	assign in_seq     = in_shot || (state_q == S_RUN);
	assign rise_at    = T_W'(ONESHOT_CYC + DG_RISE_CYC) + T_W'(ddly_act_q);
	assign fx_rise_at = T_W'(ONESHOT_CYC + FX_RISE_CYC);
	assign last_at    = (rise_at > fx_rise_at) ? rise_at : fx_rise_at;
	assign sync_busy  = (state_q != S_IDLE);
	assign one_shot   = in_shot;

	// Sync sequencer
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			state_q    <= S_IDLE;
			t_q        <= {T_W{1'b0}};
			ddly_act_q <= {DDLY_W{1'b0}};
		end else begin
			case (state_q)
				S_IDLE: begin
					if (start_req && qual_on) begin
						state_q <= S_FALL1;
					end else if (start_req) begin
						state_q    <= S_SHOT;
						t_q        <= {T_W{1'b0}};
						ddly_act_q <= ddly;
					end
				end
				S_FALL1: begin
					// First qualifying falling edge
					if (dg_fall) begin
						state_q <= S_FALL2;
					end
				end
				S_FALL2: begin
					// Second qualifying falling edge
					if (dg_fall) begin
						state_q <= S_LEAD;
					end
				end
				S_LEAD: begin
					// Lead-in before the one-shot
					state_q    <= S_SHOT;
					t_q        <= {T_W{1'b0}};
					ddly_act_q <= ddly;
				end
				S_SHOT: begin
					t_q <= t_q + 12'h001;
					if (t_q == T_W'(ONESHOT_CYC - 1)) begin
						state_q <= S_RUN;
					end
				end
				S_RUN: begin
					t_q <= t_q + 12'h001;
					if (t_q == last_at) begin
						state_q <= S_IDLE;
					end
				end
				default: begin
					state_q <= S_IDLE;
				end
			endcase
		end
	end

	// Output holds, exempt groups never stop
	// Holds move one cycle early: the clock flops add the other cycle
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			dg_hold_q <= 1'b0;
			fx_hold_q <= 1'b0;
		end else begin
			if (in_seq && t_q == T_W'(DG_LOW_CYC - 1) && !dg_exempt) begin
				dg_hold_q <= 1'b1;
			end else if (in_seq && t_q == rise_at - 12'h001) begin
				dg_hold_q <= 1'b0;
			end
			if (in_seq && t_q == T_W'(FX_LOW_CYC - 1) && !fx_exempt) begin
				fx_hold_q <= 1'b1;
			end else if (in_seq && t_q == fx_rise_at - 12'h001) begin
				fx_hold_q <= 1'b0;
			end
		end
	end

	// One-shot start
	sequence s_shot_start;
		$rose(in_shot);
	endsequence

	// Fixed group stays low for its window
	sequence s_fx_window;
		fx_hold_q [*4] ##1 !fx_hold_q;
	endsequence

	property p_shot_width;
		@(posedge sys_clk) disable iff (rst)
		s_shot_start |-> in_shot [*3] ##1 !in_shot;
	endproperty
	a_shot_width: assert property (p_shot_width) else $error("one-shot width wrong");

	property p_dg_force;
		@(posedge sys_clk) disable iff (rst)
		s_shot_start and !dg_exempt |-> !dg_hold_q [*6] ##1 dg_hold_q;
	endproperty
	a_dg_force: assert property (p_dg_force) else $error("delay group low late");

	property p_fx_force;
		@(posedge sys_clk) disable iff (rst)
		s_shot_start and !fx_exempt |-> !fx_hold_q [*8] ##1 !fx_hold_q ##1 fx_hold_q;
	endproperty
	a_fx_force: assert property (p_fx_force) else $error("fixed group low late");

	property p_fx_release;
		@(posedge sys_clk) disable iff (rst)
		$rose(fx_hold_q) |-> s_fx_window;
	endproperty
	a_fx_release: assert property (p_fx_release) else $error("fixed group rise wrong");

	property p_dg_release;
		@(posedge sys_clk) disable iff (rst)
		$fell(dg_hold_q) |-> ($past(t_q) == rise_at - 12'h001);
	endproperty
	a_dg_release: assert property (p_dg_release) else $error("delay group rise wrong");

	property p_exempt;
		@(posedge sys_clk) disable iff (rst)
		fx_exempt && $past(fx_exempt) |-> !$rose(fx_hold_q);
	endproperty
	a_exempt: assert property (p_exempt) else $error("exempt output stopped");

	property p_qual;
		@(posedge sys_clk) disable iff (rst)
		(state_q == S_FALL2 && dg_fall) |-> ##2 in_shot;
	endproperty
	a_qual: assert property (p_qual) else $error("one-shot not after second fall");

	property p_ddly_at_sync;
		@(posedge sys_clk) disable iff (rst)
		$changed(ddly_act_q) |-> $rose(in_shot);
	endproperty
	a_ddly_at_sync: assert property (p_ddly_at_sync) else $error("delay changed off sync");

	property p_load;
		@(posedge sys_clk) disable iff (rst)
		(load_q && cap_addr == ADDR_R3 && !write_lock) |=> (r3 == $past(cap_q));
	endproperty
	a_load: assert property (p_load) else $error("word not loaded");

	property p_reset_word;
		@(posedge sys_clk) disable iff (rst)
		(load_q && cap_addr == ADDR_R0 && cap_q[RESET_POS] && !write_lock)
			|=> (r0 == reg_default(3'h0)) && (r4 == reg_default(3'h4));
	endproperty
	a_reset_word: assert property (p_reset_word) else $error("reset word not honoured");

	property p_unmapped;
		@(posedge sys_clk) disable iff (rst)
		(load_q && !reg_valid(cap_addr)) |=> $stable(r3) && $stable(r5);
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped word changed state");

	property p_auto;
		@(posedge sys_clk) disable iff (rst)
		(load_q && cap_addr == ADDR_R5 && !write_lock && auto_on && state_q == S_IDLE)
			|-> ##2 (state_q != S_IDLE);
	endproperty
	a_auto: assert property (p_auto) else $error("auto sync missing");
endmodule

// [verif/dds_host_model.sv]
// Purpose: Host side of the serial programming port and the sync pin
// Assumes: Serial clock runs only inside a frame, 32 ns period
// Notes: Tasks are called by the bench; strobe and sync move on sys_clk
`timescale 1ns/1ps
module dds_host_model
	import dds_pkg::*;
(
	// Distribution clock
	input  wire logic sys_clk,
	// Serial programming pins
	output logic      ser_clk,
	output logic      ser_data,
	output logic      latch_strobe,
	// Sync pin
	output logic      sync_pin
);
	// Idle levels: clock still, strobe low, sync released
	initial begin
		ser_clk      = 1'b0;
		ser_data     = 1'b0;
		latch_strobe = 1'b0;
		sync_pin     = 1'b0;
	end

	// Shift one word top bit first, then latch it
	task automatic write_word(input logic [WORD_W-1:0] w);
		#7;
		for (int i = WORD_W - 1; i >= 0; i--) begin
			ser_data = w[i];
			#16 ser_clk = 1'b1;
			#16 ser_clk = 1'b0;
		end
		// Released line must not show the last bit
		ser_data = ~w[0];
		// Low-high-low strobe, each level held several cycles
		@(posedge sys_clk);
		latch_strobe <= 1'b1;
		repeat (4) @(posedge sys_clk);
		latch_strobe <= 1'b0;
		repeat (8) @(posedge sys_clk);
		@(negedge sys_clk);
	endtask

	// Sync level held n cycles; n is not clamped, the bench passes two or more
	task automatic pulse_sync(input int n);
		@(posedge sys_clk);
		sync_pin <= 1'b1;
		repeat (n) @(posedge sys_clk);
		sync_pin <= 1'b0;
	endtask
endmodule

// [verif/dds_core_bench.sv]
// Purpose: Self-checking bench of the serial registers and sync sequencer
// Assumes: Host model drives the pins, bench drives clock and reset
// Notes: Register rows first, then sync timing cases by hand
`timescale 1ns/1ps
module dds_core_bench;
	// Clock, reset and pins
	logic sys_clk;
	logic rst;
	logic ser_clk;
	logic ser_data;
	logic latch_strobe;
	logic sync_pin;
	// Design outputs
	logic dg_a;
	logic dg_b;
	logic fx;
	logic hs;
	logic adly;
	logic lock;
	logic busy;
	logic shot;
	// Score counters
	int   bad_count;
	int   compares;

	// Word, then expected half step, analog select, lock
	localparam logic [34:0] ROWS [8] = '{
		{32'h00000010, 3'h0},
		{32'h00000403, 3'h4},
		{32'h00002005, 3'h6},
		{32'hfffffff7, 3'h6},
		{32'hfffffff0, 3'h0},
		{32'h0000001f, 3'h1},
		{32'h00000403, 3'h1},
		{32'h0000000f, 3'h0}
	};

	// Far side of the programming port
	dds_host_model host (
		.sys_clk      (sys_clk),
		.ser_clk      (ser_clk),
		.ser_data     (ser_data),
		.latch_strobe (latch_strobe),
		.sync_pin     (sync_pin)
	);

	// Block under test
	dds_core uut (
		.sys_clk               (sys_clk),
		.rst                   (rst),
		.ser_clk               (ser_clk),
		.ser_data              (ser_data),
		.latch_strobe          (latch_strobe),
		.sync_pin              (sync_pin),
		.delay_group_out_a     (dg_a),
		.delay_group_out_b     (dg_b),
		.fixed_group_out_first (fx),
		.half_step_sel         (hs),
		.analog_delay_sel      (adly),
		.write_lock            (lock),
		.sync_busy             (busy),
		.one_shot              (shot)
	);

	// 200 MHz distribution clock
	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end

	// Compare one value and count it
	task automatic check(input logic seen, input logic exp);
		compares++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected at %0t: saw %b want %b", $time, seen, exp);
		end
	endtask

	// Verdict and end of run
	task automatic conclude();
		if (bad_count == 0 && compares > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// Bounded wait for the first one-shot cycle
	task automatic wait_shot();
		int k;
		k = 0;
		@(negedge sys_clk);
		while (shot !== 1'b1 && k < 60) begin
			@(negedge sys_clk);
			k++;
		end
		if (shot !== 1'b1) begin
			bad_count++;
			$display("unexpected at %0t: no one-shot", $time);
			conclude();
		end
	endtask

	// Bounded wait for the sequencer to start, then let it finish
	task automatic expect_busy();
		int k;
		k = 0;
		while (busy !== 1'b1 && k < 20) begin
			@(negedge sys_clk);
			k++;
		end
		check(busy, 1'b1);
		// Sequencer never started: stop here
		if (busy !== 1'b1) conclude();
		repeat (30) @(negedge sys_clk);
	endtask

	// Unqualified sync, cycle by cycle from the one-shot start
	task automatic timed_sync(input int n, input int dly, input logic ex);
		logic last;
		fork
			host.pulse_sync(n);
		join_none
		wait_shot();
		last = fx;
		for (int t = 0; t <= dly + 10; t++) begin
			if (t > 0) @(negedge sys_clk);
			check(shot, t < 3);
			check(dg_b, dg_a);
			// Low from t 7, high again once the delay has run
			if (t >= 7) check(dg_a, t == dly + 10);
			// Fixed output toggles until it is forced low
			if (!ex && t > 0 && t < 10) check(fx, !last);
			// Fixed output low t 10 to 13, high again at 14
			if (!ex && t >= 10) check(fx, t == 14);
			// Exempt fixed output toggles every cycle
			if (ex && t > 0) check(fx, !last);
			if (t >= dly + 9) check(busy, t == dly + 9);
			last = fx;
		end
	endtask

	// Qualified sync: one-shot follows a fall of the first output
	task automatic qual_sync();
		int   since;
		int   falls;
		logic last;
		fork
			host.pulse_sync(2);
		join_none
		since = 0;
		falls = 0;
		last  = dg_a;
		for (int k = 0; k < 60 && shot !== 1'b1; k++) begin
			@(negedge sys_clk);
			since++;
			if (busy === 1'b1 && last === 1'b1 && dg_a === 1'b0) begin
				falls++;
				since = 0;
			end
			last = dg_a;
		end
		// No one-shot within the bound: stop here
		if (shot !== 1'b1) begin
			bad_count++;
			$display("unexpected at %0t: no qualified one-shot", $time);
			conclude();
		end
		// Two falls seen, one-shot one or two cycles after the last
		check(falls >= 2, since <= 2);
		check(since >= 1, falls >= 2);
		repeat (30) @(negedge sys_clk);
	endtask

	// Main sequence
	initial begin
		rst       = 1'b1;
		bad_count = 0;
		compares  = 0;
		repeat (10) @(posedge sys_clk);
		rst <= 1'b0;
		@(negedge sys_clk);
		check(hs | adly | lock, 1'b0);
		check(busy | shot, 1'b0);
		// Register rows
		foreach (ROWS[i]) begin
			host.write_word(ROWS[i][34:3]);
			check(hs, ROWS[i][2]);
			check(adly, ROWS[i][1]);
			check(lock, ROWS[i][0]);
		end
		// Unqualified timing, delay 5, then fixed group exempt
		host.write_word(32'h00000054);
		host.write_word(32'h00000003);
		timed_sync(2, 5, 1'b0);
		host.write_word(32'h00040003);
		timed_sync(40, 5, 1'b1);
		// Long level gives one event only
		repeat (40) begin
			@(negedge sys_clk);
			check(shot, 1'b0);
		end
		// Odd divide, half step set, qualified, step backward
		host.write_word(32'h00030005);
		host.write_word(32'h00001c03);
		host.write_word(32'h00000054);
		qual_sync();
		// Step forward from half step set
		host.write_word(32'h00000094);
		qual_sync();
		host.write_word(32'h00001803);
		check(hs, 1'b0);
		// Sync made by flipping the polarity bit
		host.write_word(32'h00008003);
		expect_busy();
		// Auto sync on divider register write
		host.write_word(32'h04000003);
		host.write_word(32'h00030005);
		expect_busy();
		conclude();
	end
endmodule
